// [pps_cfg.svh]
// Offsets, field values, reset values and timing counts of the program sequencer
`ifndef PPS_CFG_SVH
`define PPS_CFG_SVH
`define PPS_ADDR_W 12
`define PPS_OFF_CTRL 12'h000
`define PPS_OFF_STAT 12'h004
`define PPS_PROG_BASE 12'h080
`define PPS_PROG_MASK 12'hf80
`define PPS_LINES 32
`define PPS_CTRL_EN_BIT 0
`define PPS_CTRL_GO_BIT 1
`define PPS_CTRL_LINE_LSB 8
`define PPS_STAT_LINE_LSB 8
`define PPS_STAT_POS_LSB 16
`define PPS_STAT_OUT1_BIT 24
`define PPS_STAT_OUT2_BIT 25
`define PPS_STAT_HOLD_BIT 26
`define PPS_CMD_POS 2'h0
`define PPS_CMD_LINE 2'h1
`define PPS_CMD_LEVEL 2'h2
`define PPS_CMD_END 2'h3
`define PPS_OPT_IGNORE 2'h0
`define PPS_OPT_IMMED 2'h1
`define PPS_OPT_COMPLETE 2'h2
`define PPS_SRC_OFF 2'h0
`define PPS_SRC_ON 2'h1
`define PPS_SRC_TARGET 2'h2
`define PPS_SRC_REMAIN 2'h3
`define PPS_CLK_NS 40
`define PPS_TICK_NS 1600000
`define PPS_TICK_CYC (`PPS_TICK_NS / `PPS_CLK_NS)
`define PPS_LINE_RST 25'h0000003
`endif

// [pps_pkg.sv]
// Types of the positioning program sequencer
package pps_pkg;
  typedef enum logic [1:0] {
    PPS_IDLE = 2'b00,
    PPS_RUN = 2'b01,
    PPS_HALT = 2'b11
  } pps_state_type;
  typedef struct packed {
    logic [5:0] tgt2;
    logic [5:0] tgt1;
    logic [1:0] src2;
    logic [1:0] src1;
    logic [1:0] opt2;
    logic [1:0] opt1;
    logic eval_hold;
    logic eval2;
    logic eval1;
    logic [1:0] cmd;
  } pps_line_type;
  typedef struct packed {
    logic start;
    logic abort;
    logic hold;
    logic [5:0] pos;
  } pps_motion_type;
endpackage

// [pps_sequencer.sv]
// Positioning program sequencer with APB register access
`timescale 1ns/100ps
`include "pps_cfg.svh"
//
// Notes on behaviour
// R1 - Program of up to 32 lines
// R2 - Four commands per line
// R3 - Ignore option drops edges during runs
// R4 - Immediate option aborts run and branches
// R5 - Complete option finishes run first
// R6 - Single evaluated input decides; none uses entry 1
// R7 - Each output has four sources
// R8 - Constants on entry, dynamic after start
// R9 - Evaluated hold decelerates, resumes on release
// R10 - Evaluated hold freezes the current line
// R11 - Edge detection continues during hold
// R12 - Hold never touches the outputs
// R13 - End line waits run, halts quietly
// R14 - Hold may interrupt run on end line
// R15 - Input 1 picks A, input 2 B
// R16 - Without edges the line waits forever
// R17 - No evaluation starts position entry 1
// R18 - Starting a run advances the line
// R19 - Complete option checks edges at target
// R20 - Lines processed once per tick
// R21 - Input 1 wins over input 2
// R22 - Hold input is active low
// R23 - Controller keeps inputs stable long enough
// R24 - Reset leaves sequencer inactive and quiet
module pps_sequencer #(
  parameter int TICK_CYCLES = `PPS_TICK_CYC,
  parameter int LINES = `PPS_LINES
) (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [`PPS_ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic branch_in_1_i,
  input wire logic branch_in_2_i,
  input wire logic hold_n_i,
  input wire logic run_busy_i,
  input wire logic target_reached_i,
  input wire logic remain_dist_i,
  output pps_pkg::pps_motion_type motion_o,
  output logic prog_out_1_o,
  output logic prog_out_2_o
);
  import pps_pkg::*;

  function automatic logic src_level(input logic [1:0] src, input logic tgt,
                                     input logic rem);
    case (src)
      `PPS_SRC_ON: src_level = 1'b1;
      `PPS_SRC_TARGET: src_level = tgt;
      `PPS_SRC_REMAIN: src_level = rem;
      default: src_level = 1'b0;
    endcase
  endfunction

  pps_line_type prog_reg [LINES];
  pps_state_type state_reg;
  logic [4:0] line_reg;
  logic entry_reg;
  logic [31:0] tick_cnt_reg;
  logic tick_reg;
  logic en_reg;
  logic [4:0] start_line_reg;
  logic in1_prev_reg;
  logic in2_prev_reg;
  logic e1_lat_reg;
  logic e2_lat_reg;
  logic [1:0] src1_reg;
  logic [1:0] src2_reg;
  logic [5:0] last_pos_reg;

  //==========================================================
  // APB slave
  logic setup;
  logic wr_acc;
  logic go_wr;
  logic prog_hit;
  logic [4:0] prog_idx;
  assign setup = psel_i & ~penable_i;
  assign wr_acc = psel_i & penable_i & pready_o & pwrite_i;
  assign prog_hit = (paddr_i & `PPS_PROG_MASK) == `PPS_PROG_BASE;
  assign prog_idx = paddr_i[6:2];
  assign go_wr = wr_acc && paddr_i == `PPS_OFF_CTRL && pwdata_i[`PPS_CTRL_GO_BIT];

  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h0;
    end
    else
    begin
      pready_o <= setup;
      pslverr_o <= setup & ~(prog_hit | paddr_i == `PPS_OFF_CTRL |
                             paddr_i == `PPS_OFF_STAT);
      prdata_o <= 32'h0;
      if (setup && !pwrite_i)
      begin
        if (prog_hit)
          prdata_o <= {7'h0, prog_reg[prog_idx]};
        else if (paddr_i == `PPS_OFF_CTRL)
          prdata_o <= {19'h0, start_line_reg, 7'h0, en_reg};
        else if (paddr_i == `PPS_OFF_STAT)
          prdata_o <= {5'h0, motion_o.hold, prog_out_2_o, prog_out_1_o,
                       2'h0, last_pos_reg, 3'h0, line_reg, 6'h0, state_reg};
      end
    end
  end

  // Program store, written over the bus R1
  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      for (int i = 0; i < LINES; i++)
        prog_reg[i] <= `PPS_LINE_RST;
    end
    else if (wr_acc && prog_hit)
      prog_reg[prog_idx] <= pwdata_i[24:0];
  end

  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      en_reg <= 1'b0;
      start_line_reg <= 5'h0;
    end
    else if (wr_acc && paddr_i == `PPS_OFF_CTRL)
    begin
      en_reg <= pwdata_i[`PPS_CTRL_EN_BIT];
      start_line_reg <= pwdata_i[`PPS_CTRL_LINE_LSB +: 5];
    end
  end

  //==========================================================
  // Processing tick
  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      tick_cnt_reg <= 32'h0;
      tick_reg <= 1'b0;
    end
    else if (state_reg != PPS_RUN || tick_cnt_reg == 32'(TICK_CYCLES - 1))
    begin
      tick_cnt_reg <= 32'h0;
      tick_reg <= state_reg == PPS_RUN; // R20
    end
    else
    begin
      tick_cnt_reg <= tick_cnt_reg + 32'h1;
      tick_reg <= 1'b0;
    end
  end

  //==========================================================
  // Line decode and decision
  pps_line_type ln;
  logic act;
  logic hold_blk;
  logic pend1;
  logic pend2;
  logic sel2;
  logic pend;
  logic autom;
  logic [1:0] opt;
  logic [5:0] tgt;
  logic take;
  logic drop;
  logic do_start;
  logic do_jump;
  logic consume;

  always_comb
  begin
    ln = prog_reg[line_reg];
    act = tick_reg && state_reg == PPS_RUN;
    hold_blk = ln.eval_hold & ~hold_n_i; // R22
    pend1 = ln.eval1 & e1_lat_reg;
    pend2 = ln.eval2 & e2_lat_reg;
    sel2 = pend2 & ~pend1; // R21
    pend = pend1 | pend2;
    autom = ~ln.eval1 & ~ln.eval2; // R6
    opt = sel2 ? ln.opt2 : ln.opt1;
    tgt = autom ? ln.tgt1 : (sel2 ? ln.tgt2 : ln.tgt1); // R15 R17
    take = autom | (pend & (opt == `PPS_OPT_IMMED | !run_busy_i)); // R4 R5 R19 R16
    drop = ~autom & pend & opt == `PPS_OPT_IGNORE & run_busy_i; // R3
    do_start = act & ~hold_blk & take & ln.cmd == `PPS_CMD_POS; // R10
    do_jump = act & ~hold_blk & take & ln.cmd == `PPS_CMD_LINE;
    consume = act & ~hold_blk & (ln.cmd == `PPS_CMD_POS | ln.cmd == `PPS_CMD_LINE) &
              (take | drop);
  end

  //==========================================================
  // Branch edge latches, set wins over clear
  logic edge1;
  logic edge2;
  assign edge1 = branch_in_1_i & ~in1_prev_reg;
  assign edge2 = branch_in_2_i & ~in2_prev_reg;

  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      in1_prev_reg <= 1'b0;
      in2_prev_reg <= 1'b0;
      e1_lat_reg <= 1'b0;
      e2_lat_reg <= 1'b0;
    end
    else
    begin
      in1_prev_reg <= branch_in_1_i;
      in2_prev_reg <= branch_in_2_i;
      e1_lat_reg <= (e1_lat_reg & ~consume) | edge1; // R11
      e2_lat_reg <= (e2_lat_reg & ~consume) | edge2; // R11
    end
  end

  //==========================================================
  // Sequencing state and line pointer
  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      state_reg <= PPS_IDLE; // R24
      line_reg <= 5'h0;
      entry_reg <= 1'b0;
    end
    else if (go_wr && pwdata_i[`PPS_CTRL_EN_BIT])
    begin
      state_reg <= PPS_RUN;
      line_reg <= pwdata_i[`PPS_CTRL_LINE_LSB +: 5];
      entry_reg <= 1'b1;
    end
    else if (!en_reg)
      state_reg <= PPS_IDLE;
    else if (act)
    begin
      entry_reg <= 1'b0;
      case (ln.cmd) // R2
        `PPS_CMD_POS:
        begin
          if (do_start)
          begin
            line_reg <= line_reg + 5'h1; // R18
            entry_reg <= 1'b1;
          end
        end
        `PPS_CMD_LINE:
        begin
          if (do_jump)
          begin
            line_reg <= tgt[4:0];
            entry_reg <= 1'b1;
          end
        end
        `PPS_CMD_LEVEL:
        begin
          if (!hold_blk)
          begin
            line_reg <= branch_in_1_i ? ln.tgt1[4:0] : ln.tgt2[4:0];
            entry_reg <= 1'b1;
          end
        end
        default:
        begin
          if (!run_busy_i && !hold_blk)
            state_reg <= PPS_HALT; // R13
        end
      endcase
    end
  end

  //==========================================================
  // Motion core requests
  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      motion_o <= '0; // R24
      last_pos_reg <= 6'h0;
    end
    else
    begin
      motion_o.start <= do_start;
      motion_o.abort <= (do_start | do_jump) & ~autom & opt == `PPS_OPT_IMMED &
                        run_busy_i; // R4
      motion_o.hold <= state_reg == PPS_RUN & hold_blk; // R9 R14
      if (do_start)
      begin
        motion_o.pos <= tgt;
        last_pos_reg <= tgt;
      end
    end
  end

  //==========================================================
  // Output sources
  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      src1_reg <= `PPS_SRC_OFF;
      src2_reg <= `PPS_SRC_OFF;
    end
    else if (act && ln.cmd != `PPS_CMD_END) // R13
    begin
      if ((entry_reg && !ln.src1[1]) || (do_start && ln.src1[1]))
        src1_reg <= ln.src1; // R7 R8
      if ((entry_reg && !ln.src2[1]) || (do_start && ln.src2[1]))
        src2_reg <= ln.src2; // R7 R8
    end
  end

  // Outputs ignore the hold input
  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      prog_out_1_o <= 1'b0;
      prog_out_2_o <= 1'b0;
    end
    else
    begin
      prog_out_1_o <= src_level(src1_reg, target_reached_i, remain_dist_i); // R12
      prog_out_2_o <= src_level(src2_reg, target_reached_i, remain_dist_i); // R12
    end
  end

  //==========================================================
  // Checks
  a_hold_no_start: assert property (@(posedge mclk_i) disable iff (!resetn_i) // R10
    act && hold_blk |=> !motion_o.start && line_reg == $past(line_reg))
    else $error("line moved under hold");
  a_start_advance: assert property (@(posedge mclk_i) disable iff (!resetn_i) // R18
    do_start && !go_wr && en_reg |=> motion_o.start && line_reg == 5'($past(line_reg) + 1))
    else $error("start did not advance line");
  a_edge_latched: assert property (@(posedge mclk_i) disable iff (!resetn_i) // R11
    edge1 |=> e1_lat_reg)
    else $error("branch edge lost");
  a_prio_input_one: assert property (@(posedge mclk_i) disable iff (!resetn_i) // R21
    do_start && pend1 && pend2 |=> motion_o.pos == $past(ln.tgt1))
    else $error("input two won over input one");
  a_ignore_busy: assert property (@(posedge mclk_i) disable iff (!resetn_i) // R3
    act && !autom && pend && opt == `PPS_OPT_IGNORE && run_busy_i
    |=> !motion_o.start ##1 (!e1_lat_reg || $past(edge1) || $past(edge1, 2)))
    else $error("edge not discarded during run");
  a_immed_abort: assert property (@(posedge mclk_i) disable iff (!resetn_i) // R4
    do_start && !autom && opt == `PPS_OPT_IMMED && run_busy_i
    |=> motion_o.abort && motion_o.start)
    else $error("immediate option did not abort");
  a_end_quiet: assert property (@(posedge mclk_i) disable iff (!resetn_i) // R13
    state_reg == PPS_HALT |=> !motion_o.start && $stable(src1_reg) && $stable(src2_reg))
    else $error("halted program acted");
  a_wait_no_edge: assert property (@(posedge mclk_i) disable iff (!resetn_i) // R16
    act && ln.cmd == `PPS_CMD_POS && !autom && !pend && !go_wr
    |=> !motion_o.start && line_reg == $past(line_reg))
    else $error("line left without edge");
endmodule

// [pps_motion_model.sv]
// Motion core model answering the sequencer's run requests
`timescale 1ns/100ps
module pps_motion_model (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input pps_pkg::pps_motion_type motion_i,
  input wire logic [15:0] run_len_i,
  output logic run_busy_o,
  output logic target_reached_o,
  output logic remain_dist_o
);
  import pps_pkg::*;
  logic [15:0] left_reg;
  // ====================
  // Run counter: a start reloads it, hold pauses it, abort is ignored
  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      left_reg <= 16'h0;
    else if (motion_i.start)
      left_reg <= run_len_i;
    else if (left_reg != 16'h0 && !motion_i.hold)
      left_reg <= left_reg - 16'h1;
  end
  assign run_busy_o = (left_reg != 16'h0);
  assign target_reached_o = !run_busy_o;
  assign remain_dist_o = run_busy_o && (left_reg < 16'h8);
endmodule

// [test_pps_sequencer.sv]
// Self-checking bench of the positioning program sequencer
`timescale 1ns/100ps
`include "pps_cfg.svh"
module test_pps_sequencer;
  import pps_pkg::*;
  localparam logic [1:0] PS = `PPS_CMD_POS;
  localparam logic [1:0] EN = `PPS_CMD_END;
  localparam logic [1:0] IG = `PPS_OPT_IGNORE;
  localparam logic [1:0] OF = `PPS_SRC_OFF;
  logic mclk_i = 1'h0;
  logic resetn_i = 1'h0;
  logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0, b1 = 1'h0, b2 = 1'h0, hold_n = 1'h1;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [15:0] run_len = 16'h1e;
  logic pready, pslverr, busy, tgt, rem, out1, out2, er, got, ab, bz;
  logic [5:0] p;
  pps_motion_type mot;
  int err_total = 0, cmp_count = 0, cyc = 0;
  always #20 mclk_i = ~mclk_i;
  pps_sequencer #(.TICK_CYCLES(8)) pps_sequencer_i (.mclk_i(mclk_i), .resetn_i(resetn_i),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .branch_in_1_i(b1), .branch_in_2_i(b2), .hold_n_i(hold_n), .run_busy_i(busy),
    .target_reached_i(tgt), .remain_dist_i(rem), .motion_o(mot), .prog_out_1_o(out1),
    .prog_out_2_o(out2));
  pps_motion_model pps_motion_model_i (.mclk_i(mclk_i), .resetn_i(resetn_i), .motion_i(mot),
    .run_len_i(run_len), .run_busy_o(busy), .target_reached_o(tgt), .remain_dist_o(rem));
  // ====================
  // Shared tasks
  task automatic print_verdict();
    if (err_total == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge mclk_i)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      err_total++;
      print_verdict();
    end
  end
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e)
    begin
      err_total++;
      $display("mismatch %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk_i);
    penable <= 1'h1;
    do
    begin
      @(posedge mclk_i);
    end
    while (pready !== 1'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  function automatic logic [31:0] ln(logic [1:0] c, logic e1, logic e2, logic eh,
    logic [1:0] o, logic [1:0] s1, logic [5:0] t1, logic [5:0] t2);
    pps_line_type l;
    l = '{t2, t1, OF, s1, o, o, eh, e2, e1, c};
    return {7'h0, l};
  endfunction
  task automatic wr(input int i, input logic [31:0] v);
    apb(1'h1, 12'(`PPS_PROG_BASE + 4 * i), v);
  endtask
  task automatic go(input logic [4:0] l);
    apb(1'h1, `PPS_OFF_CTRL, 32'h0);
    apb(1'h1, `PPS_OFF_CTRL, {19'h0, l, 8'h3});
  endtask
  task automatic wst(input int lim);
    got = 1'h0;
    repeat (lim)
    begin
      @(posedge mclk_i);
      if (mot.start === 1'h1)
      begin
        got = 1'h1;
        p = mot.pos;
        ab = mot.abort;
        bz = busy;
        break;
      end
    end
  endtask
  task automatic pulse(input logic x1, input logic x2);
    @(posedge mclk_i);
    b1 <= x1;
    b2 <= x2;
    fork
      begin
        repeat (10) @(posedge mclk_i);
        b1 <= 1'h0;
        b2 <= 1'h0;
      end
    join_none
  endtask
  // ====================
  // Scenarios
  task automatic s_reset();
    chk("motion", 32'(mot), 32'h0);
    chk("outs", {out2, out1}, 32'h0);
    apb(1'h0, `PPS_OFF_STAT, 32'h0);
    chk("stat", rd, 32'h0);
    apb(1'h0, 12'h008, 32'h0);
    chk("unmapped", {er, rd[30:0]}, 32'h80000000);
  endtask
  task automatic s_linear();
    wr(31, ln(PS, 1'h0, 1'h0, 1'h0, IG, `PPS_SRC_ON, 6'h05, 6'h0));
    wr(0, ln(PS, 1'h0, 1'h0, 1'h0, IG, `PPS_SRC_ON, 6'h07, 6'h0));
    wr(1, 32'(`PPS_LINE_RST));
    go(5'h1f);
    wst(60);
    chk("pos a", {got, p}, {1'h1, 6'h05});
    wst(100);
    chk("pos b", {got, p}, {1'h1, 6'h07});
    chk("out1", out1, 1'h1);
    wst(100);
    chk("no run", got, 1'h0);
    apb(1'h0, `PPS_OFF_STAT, 32'h0);
    chk("halt", {out1, rd[1:0]}, 3'h7);
  endtask
  task automatic s_branch();
    wr(0, ln(PS, 1'h1, 1'h1, 1'h0, IG, OF, 6'h0a, 6'h14));
    go(5'h0);
    wst(40);
    chk("wait", got, 1'h0);
    pulse(1'h0, 1'h1);
    wst(40);
    chk("in2", {got, p}, {1'h1, 6'h14});
    repeat (60) @(posedge mclk_i);
    go(5'h0);
    pulse(1'h1, 1'h1);
    wst(40);
    chk("both", {got, p}, {1'h1, 6'h0a});
    repeat (60) @(posedge mclk_i);
    wr(0, ln(PS, 1'h0, 1'h1, 1'h0, IG, OF, 6'h0a, 6'h14));
    go(5'h0);
    pulse(1'h1, 1'h0);
    wst(40);
    chk("only 2", got, 1'h0);
  endtask
  task automatic s_hold();
    run_len <= 16'h64;
    wr(0, ln(PS, 1'h1, 1'h0, 1'h1, IG, OF, 6'h0a, 6'h0));
    wr(1, ln(EN, 1'h0, 1'h0, 1'h1, IG, OF, 6'h0, 6'h0));
    hold_n <= 1'h0;
    go(5'h0);
    pulse(1'h1, 1'h0);
    wst(40);
    chk("held", got, 1'h0);
    hold_n <= 1'h1;
    wst(40);
    chk("resume", {got, p}, {1'h1, 6'h0a});
    hold_n <= 1'h0;
    repeat (20) @(posedge mclk_i);
    chk("stop", {mot.hold, busy, out2, out1}, 4'hc);
    hold_n <= 1'h1;
    repeat (20) @(posedge mclk_i);
    chk("go on", mot.hold, 1'h0);
    repeat (150) @(posedge mclk_i);
  endtask
  task automatic s_opts();
    logic [1:0] o[3] = '{`PPS_OPT_IGNORE, `PPS_OPT_IMMED, `PPS_OPT_COMPLETE};
    for (int k = 0; k < 3; k++)
    begin
      wr(0, ln(PS, 1'h0, 1'h0, 1'h0, IG, OF, 6'h01, 6'h0));
      wr(1, ln(PS, 1'h1, 1'h0, 1'h0, o[k], OF, 6'h09, 6'h0));
      wr(2, 32'(`PPS_LINE_RST));
      go(5'h0);
      wst(40);
      repeat (10) @(posedge mclk_i);
      pulse(1'h1, 1'h0);
      wst(300);
      if (k == 0)
        chk("ignore", got, 1'h0);
      else
        chk("branch", {got, p, ab, bz}, {1'h1, 6'h09, k == 1, k == 1});
      repeat (150) @(posedge mclk_i);
    end
  endtask
  task automatic s_sources();
    run_len <= 16'h14;
    wr(0, ln(`PPS_CMD_LINE, 1'h0, 1'h0, 1'h0, IG, OF, 6'h02, 6'h0));
    wr(1, ln(PS, 1'h0, 1'h0, 1'h0, IG, OF, 6'h2a, 6'h0));
    wr(2, ln(PS, 1'h0, 1'h0, 1'h0, IG, `PPS_SRC_TARGET, 6'h03, 6'h0) |
      {19'h0, `PPS_SRC_REMAIN, 11'h0});
    go(5'h0);
    wst(40);
    chk("jump", {got, p}, {1'h1, 6'h03});
    repeat (4) @(posedge mclk_i);
    chk("src run", {out2, out1}, 2'h0);
    repeat (13) @(posedge mclk_i);
    chk("src remain", {out2, out1}, 2'h2);
    repeat (12) @(posedge mclk_i);
    chk("src target", {out2, out1}, 2'h1);
  endtask
  initial
  begin
    repeat (16) @(posedge mclk_i);
    resetn_i <= 1'h1;
    s_reset();
    s_linear();
    s_branch();
    s_hold();
    s_opts();
    s_sources();
    print_verdict();
  end
endmodule
